// [core/ecl_loader.sv]
// Configuration loader: two-wire EEPROM autoload and config-space registers.
// Assumes config cycles arrive as one-cycle strobes in the core clock domain
// and that the EEPROM pins are open-drain with external pull-ups.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader
	import ecl_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	input  wire logic        I_CFG_WR,
	input  wire logic        I_CFG_RD,
	input  wire logic [7:0]  I_CFG_ADDR,
	input  wire logic [3:0]  I_CFG_BE,
	input  wire logic [31:0] I_CFG_WDATA,
	output logic      [31:0] O_CFG_RDATA,
	output logic             O_CFG_RVALID,
	input  wire logic        I_EEPROM_LOAD_DISABLE_PIN,
	input  wire logic        I_AUX_POWER_SENSE,
	input  wire logic        I_EEPROM_DATA_LINE,
	output logic             O_EEPROM_DATA_LINE_O,
	output logic             O_EEPROM_DATA_LINE_OE,
	output logic             O_EEPROM_CLOCK_LINE_O,
	output logic             O_EEPROM_CLOCK_LINE_OE,
	input  wire logic        I_HOST_EE_EN,
	input  wire logic        I_HOST_EE_CLK,
	input  wire logic        I_HOST_EE_DAT,
	output logic             O_HOST_EE_DAT,
	output logic             O_LOAD_BUSY,
	output logic             O_LOAD_OK
);
	ecl_state_t s_q;
	ecl_state_t s_d;
	logic       tick;
	logic       last;
	logic [15:0] power_mgmt_capabilities;

	// capability word derived from the dynamic config copies
	always_comb begin
		power_mgmt_capabilities = {1'b0, {4{s_q.dcfg[31]}}, 2'b11,
		       s_q.aux_s2 ? s_q.dcfg[29:27] : 3'b000,
		       1'b1, 2'b00, 3'b010};
	end

	always_comb begin
		s_d = s_q;
		tick = (s_q.qcnt == QCNT_W'(QTR_CYC - 1));
		last = (s_q.byten == EE_LAST_BYTE);
		s_d.dis_s1 = I_EEPROM_LOAD_DISABLE_PIN;
		s_d.dis_s2 = s_q.dis_s1;
		s_d.aux_s1 = I_AUX_POWER_SENSE;
		s_d.aux_s2 = s_q.aux_s1;
		s_d.sda_s1 = I_EEPROM_DATA_LINE;
		s_d.sda_s2 = s_q.sda_s1;
		s_d.rvalid = 1'b0;
		s_d.qcnt = tick ? '0 : s_q.qcnt + 1'b1;
		if (tick) begin
			s_d.ph = s_q.ph + 2'd1;
		end
		case (s_q.st)
			LD_WAIT: begin
				if (tick) begin
					s_d.ph = 2'd0;
					s_d.stage = 2'd0;
					s_d.byten = 4'h0;
					s_d.bad = 1'b0;
					s_d.ok = 1'b0;
					s_d.st = s_q.dis_s2 ? LD_DONE : LD_START;
				end
			end
			LD_START: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: begin
							s_d.scl = 1'b0;
							s_d.sda = 1'b1;
						end
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.sda = 1'b0;
						default: begin
							s_d.scl = 1'b0;
							s_d.bitn = 3'd7;
							s_d.sh = (s_q.stage == 2'd2) ? EE_ADDR_RD : EE_ADDR_WR;
							s_d.st = LD_TX;
						end
					endcase
				end
			end
			LD_TX: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: s_d.sda = s_q.sh[7];
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.scl = 1'b1;
						default: begin
							s_d.scl = 1'b0;
							s_d.sh = {s_q.sh[6:0], 1'b0};
							s_d.bitn = s_q.bitn - 3'd1;
							if (s_q.bitn == 3'd0) begin
								s_d.st = LD_TXACK;
							end
						end
					endcase
				end
			end
			LD_TXACK: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: s_d.sda = 1'b1;
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.nack = s_q.sda_s2;
						default: begin
							s_d.scl = 1'b0;
							s_d.bitn = 3'd7;
							if (s_q.nack) begin
								// no device answered: leave defaults
								s_d.st = LD_STOP;
							end else if (s_q.stage == 2'd0) begin
								s_d.stage = 2'd1;
								s_d.sh = EE_BYTE_ADDR;
								s_d.st = LD_TX;
							end else if (s_q.stage == 2'd1) begin
								s_d.stage = 2'd2;
								s_d.st = LD_START;
							end else begin
								s_d.st = LD_RX;
							end
						end
					endcase
				end
			end
			LD_RX: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: s_d.sda = 1'b1;
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.sh = {s_q.sh[6:0], s_q.sda_s2};
						default: begin
							s_d.scl = 1'b0;
							s_d.bitn = s_q.bitn - 3'd1;
							if (s_q.bitn == 3'd0) begin
								s_d.st = LD_RXACK;
								case (s_q.byten)
									4'h0: s_d.bad = (s_q.sh != EE_SIG0);
									4'h1: s_d.bad = s_q.bad | (s_q.sh != EE_SIG1);
									4'h2: s_d.ld_vid[7:0] = s_q.sh;
									4'h3: s_d.ld_vid[15:8] = s_q.sh;
									4'h4: s_d.ld_sid[7:0] = s_q.sh;
									4'h5: s_d.ld_sid[15:8] = s_q.sh;
									4'h6: s_d.ld_cfg[7:0] = s_q.sh;
									default: s_d.ld_cfg[15:8] = s_q.sh;
								endcase
							end
						end
					endcase
				end
			end
			LD_RXACK: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: begin
							s_d.nack = last | s_q.bad;
							s_d.sda = last | s_q.bad;
						end
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.scl = 1'b1;
						default: begin
							s_d.scl = 1'b0;
							s_d.bitn = 3'd7;
							if (s_q.nack) begin
								s_d.ok = last & ~s_q.bad;
								s_d.st = LD_STOP;
							end else begin
								s_d.byten = s_q.byten + 4'h1;
								s_d.st = LD_RX;
							end
						end
					endcase
				end
			end
			LD_STOP: begin
				if (tick) begin
					case (s_q.ph)
						2'd0: begin
							s_d.scl = 1'b0;
							s_d.sda = 1'b0;
						end
						2'd1: s_d.scl = 1'b1;
						2'd2: s_d.sda = 1'b1;
						default: begin
							if (s_q.ok) begin
								// commit only a complete, signed image
								s_d.vid = s_q.ld_vid;
								s_d.sid = s_q.ld_sid;
								s_d.dcfg = {s_q.ld_cfg[15:8] & DYN_CFG_WR_MASK[31:24],
								            s_q.ld_cfg[7:0], s_q.dcfg[15:0]};
							end
							s_d.st = LD_DONE;
						end
					endcase
				end
			end
			LD_DONE: begin
				// host bit-bangs the pins once the load is over
				s_d.scl = I_HOST_EE_EN ? I_HOST_EE_CLK : 1'b1;
				s_d.sda = I_HOST_EE_EN ? I_HOST_EE_DAT : 1'b1;
			end
			default: s_d.st = LD_WAIT;
		endcase

		if (I_CFG_WR && I_CFG_ADDR == OFS_SUBSYS_SHADOW) begin
			if (I_CFG_BE[0]) s_d.vid[7:0] = I_CFG_WDATA[7:0];
			if (I_CFG_BE[1]) s_d.vid[15:8] = I_CFG_WDATA[15:8];
			if (I_CFG_BE[2]) s_d.sid[7:0] = I_CFG_WDATA[23:16];
			if (I_CFG_BE[3]) s_d.sid[15:8] = I_CFG_WDATA[31:24];
		end
		if (I_CFG_WR && I_CFG_ADDR == OFS_DYN_CFG) begin
			if (I_CFG_BE[0]) s_d.dcfg[7:0] = I_CFG_WDATA[7:0];
			if (I_CFG_BE[1]) s_d.dcfg[15:8] = I_CFG_WDATA[15:8];
			if (I_CFG_BE[2]) s_d.dcfg[23:16] = I_CFG_WDATA[23:16];
			if (I_CFG_BE[3]) begin
				s_d.dcfg[31:24] = I_CFG_WDATA[31:24] & DYN_CFG_WR_MASK[31:24];
			end
		end
		if (I_CFG_RD) begin
			s_d.rvalid = 1'b1;
			case (I_CFG_ADDR)
				OFS_SUBSYS_IDENT: s_d.rdata = {s_q.sid, s_q.vid};
				OFS_PM_CAP:       s_d.rdata = {power_mgmt_capabilities, PM_CAP_ID_WORD};
				OFS_DYN_CFG:      s_d.rdata = s_q.dcfg & DYN_CFG_WR_MASK;
				default:          s_d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			s_q <= '{st: LD_WAIT, scl: 1'b1, sda: 1'b1, dis_s1: 1'b1, dis_s2: 1'b1,
			         vid: RST_IDENT, sid: RST_IDENT, dcfg: RST_DYN_CFG,
			         default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// open-drain: drive low only, enable while pulling down
	assign O_EEPROM_DATA_LINE_O  = 1'b0;
	assign O_EEPROM_DATA_LINE_OE = ~s_q.sda;
	assign O_EEPROM_CLOCK_LINE_O = 1'b0;
	assign O_EEPROM_CLOCK_LINE_OE = ~s_q.scl;
	assign O_CFG_RDATA  = s_q.rdata;
	assign O_CFG_RVALID = s_q.rvalid;
	assign O_HOST_EE_DAT = s_q.sda_s2;
	assign O_LOAD_BUSY  = (s_q.st != LD_DONE);
	assign O_LOAD_OK    = s_q.ok & (s_q.st == LD_DONE);
endmodule
`default_nettype wire

// [core/ecl_pkg.sv]
// Constants, types and state record for the power-up configuration loader.
// Assumes a 100 MHz core clock and a two-wire EEPROM at device address 0x50.
package ecl_pkg;
	localparam logic [7:0]  OFS_SUBSYS_IDENT  = 8'h2C;
	localparam logic [7:0]  OFS_PM_CAP        = 8'h40;
	localparam logic [7:0]  OFS_DYN_CFG       = 8'hF8;
	localparam logic [7:0]  OFS_SUBSYS_SHADOW = 8'hFC;
	localparam logic [15:0] RST_IDENT         = 16'h0000;
	localparam logic [31:0] RST_DYN_CFG       = 32'h00000000;
	localparam logic [15:0] PM_CAP_ID_WORD    = 16'h0001;
	localparam logic [31:0] DYN_CFG_WR_MASK   = 32'hF8FFFFFF;
	localparam logic [7:0]  EE_ADDR_WR        = 8'hA0;
	localparam logic [7:0]  EE_ADDR_RD        = 8'hA1;
	localparam logic [7:0]  EE_BYTE_ADDR      = 8'h00;
	// signature values are arbitrary
	localparam logic [7:0]  EE_SIG0           = 8'h55;
	localparam logic [7:0]  EE_SIG1           = 8'hAA;
	localparam int          EE_MAX_BYTES      = 12;
	localparam logic [3:0]  EE_LAST_BYTE      = 4'h7;
	localparam int          CLK_MHZ           = 100;
	localparam int          EE_BIT_NS         = 5000;
	localparam int          QTR_CYC           = EE_BIT_NS * CLK_MHZ / 4000;
	localparam int          QCNT_W            = 9;

	typedef enum logic [3:0] {
		LD_WAIT  = 4'h0,
		LD_START = 4'h1,
		LD_TX    = 4'h2,
		LD_TXACK = 4'h3,
		LD_RX    = 4'h4,
		LD_RXACK = 4'h5,
		LD_STOP  = 4'h6,
		LD_DONE  = 4'h7
	} ecl_st_t;

	typedef struct packed {
		ecl_st_t           st;
		logic [1:0]        ph;
		logic [2:0]        bitn;
		logic [3:0]        byten;
		logic [1:0]        stage;
		logic [7:0]        sh;
		logic              nack;
		logic              bad;
		logic              ok;
		logic [QCNT_W-1:0] qcnt;
		logic              scl;
		logic              sda;
		logic              dis_s1;
		logic              dis_s2;
		logic              aux_s1;
		logic              aux_s2;
		logic              sda_s1;
		logic              sda_s2;
		logic [15:0]       ld_vid;
		logic [15:0]       ld_sid;
		logic [15:0]       ld_cfg;
		logic [15:0]       vid;
		logic [15:0]       sid;
		logic [31:0]       dcfg;
		logic [31:0]       rdata;
		logic              rvalid;
	} ecl_state_t;
endpackage

// [core/ecl_unused_guard.sv]
// Empty on purpose: none.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/ecl_monitor.sv]
// Checker for the loader's config port and EEPROM clock pin.
// Bound into every ecl_loader; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ecl_monitor
	import ecl_pkg::*;
(
	input wire logic        I_CLK,
	input wire logic        I_RSTN,
	input wire logic        I_CFG_WR,
	input wire logic        I_CFG_RD,
	input wire logic [7:0]  I_CFG_ADDR,
	input wire logic [3:0]  I_CFG_BE,
	input wire logic [31:0] I_CFG_WDATA,
	input wire logic [31:0] O_CFG_RDATA,
	input wire logic        I_AUX_POWER_SENSE,
	input wire logic        O_EEPROM_CLOCK_LINE_OE,
	input wire logic        O_LOAD_BUSY,
	input wire logic        O_LOAD_OK
);
	logic [9:0] gap_q;
	wire        rd_x  = I_CFG_RD && !I_CFG_WR;
	wire        rd_cap = rd_x && I_CFG_ADDR == OFS_PM_CAP;
	wire        rd_dc = rd_x && I_CFG_ADDR == OFS_DYN_CFG;
	wire        rd_id = rd_x && I_CFG_ADDR == OFS_SUBSYS_IDENT;
	wire        wr_dc = I_CFG_WR && I_CFG_BE == 4'hF && I_CFG_ADDR == OFS_DYN_CFG;
	wire        wr_sh = I_CFG_WR && I_CFG_BE == 4'hF && I_CFG_ADDR == OFS_SUBSYS_SHADOW;
	// cycles since the clock line last moved
	always_ff @(posedge I_CLK or negedge I_RSTN)
		if (!I_RSTN)
			gap_q <= 10'h000;
		else
			gap_q <= $changed(O_EEPROM_CLOCK_LINE_OE) ? 10'h000 : gap_q + {9'h000, ~&gap_q};
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	property p_dc_rsvd; rd_dc |=> O_CFG_RDATA[26:24] == 3'h0; endproperty
	a_dc_rsvd: assert property (p_dc_rsvd) else $error("reserved bits set");
	property p_dc_store;
		wr_dc ##1 rd_dc |=> O_CFG_RDATA == ($past(I_CFG_WDATA, 2) & DYN_CFG_WR_MASK);
	endproperty
	a_dc_store: assert property (p_dc_store) else $error("config word lost");
	property p_sh_show; wr_sh ##1 rd_id |=> O_CFG_RDATA == $past(I_CFG_WDATA, 2); endproperty
	a_sh_show: assert property (p_sh_show) else $error("ident not shown");
	property p_sh_wo;
		rd_x && I_CFG_ADDR == OFS_SUBSYS_SHADOW |=> O_CFG_RDATA == 32'h00000000;
	endproperty
	a_sh_wo: assert property (p_sh_wo) else $error("shadow readable");
	property p_wake; rd_cap |=> O_CFG_RDATA[30:27] == {4{O_CFG_RDATA[30]}}; endproperty
	a_wake: assert property (p_wake) else $error("wake bits differ");
	property p_aux; (!I_AUX_POWER_SENSE)[*4] ##0 rd_cap |=> O_CFG_RDATA[24:22] == 3'h0; endproperty
	a_aux: assert property (p_aux) else $error("aux bits set");
	property p_link;
		O_LOAD_BUSY && $changed(O_EEPROM_CLOCK_LINE_OE) |-> gap_q >= 10'(QTR_CYC - 1);
	endproperty
	a_link: assert property (p_link) else $error("clock phase short");
	property p_ok; O_LOAD_OK |-> !O_LOAD_BUSY; endproperty
	a_ok: assert property (p_ok) else $error("ok while busy");
endmodule
bind ecl_loader ecl_monitor ecl_monitor_i (.*);
`default_nettype wire

// [sim/ecl_ee_model.sv]
// Two-wire EEPROM model with an eight-byte image.
// Sees resolved line levels; pulls data low with o_pull.
`timescale 1ns/1ps
`default_nettype none
module ecl_ee_model (
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_bad,
	output logic      o_pull
);
	logic [7:0] mem [0:7] = '{8'h55, 8'hAA, 8'h34, 8'h12, 8'h78, 8'h56, 8'h3C, 8'hAF};
	logic [7:0] sh = 8'h00;
	logic       act = 1'b0;
	logic       nak = 1'b0;
	int         n = 0;
	int         m = 0;
	int         ptr = 5;
	logic [7:0] cur = 8'h00;
	function automatic logic [7:0] byte_at(input int p);
		return (p == 0 && i_bad) ? 8'h5A : mem[p % 8];
	endfunction
	initial o_pull = 1'b0;
	always @(negedge i_sda) begin
		if (i_scl) begin // start
			act = 1'b1;
			n = -1;
			m = 0;
		end
	end
	always @(posedge i_sda) begin
		if (i_scl) begin // stop
			act = 1'b0;
			o_pull = 1'b0;
		end
	end
	always @(posedge i_scl) begin
		if (act && n >= 0 && n < 8 && m < 2)
			sh = {sh[6:0], i_sda};
		if (act && n == 8 && m == 2)
			nak = i_sda;
	end
	always @(negedge i_scl) begin
		if (act) begin
			n++;
			if (n == 9) begin
				n = 0;
				if (m == 1)
					ptr = int'(sh); // dummy write sets the address
				if (m == 2)
					ptr++; // sequential read
				if (m == 2 && nak)
					act = 1'b0;
				if (m == 0)
					m = sh[0] ? 2 : 1;
			end
		end
		// data moves only with the clock low
		cur = byte_at(ptr);
		o_pull = act && (m == 2 ? n < 8 && !cur[7 - n] : n == 8 && (m == 1 || sh[7:1] == 7'h50));
	end
endmodule
`default_nettype wire

// [sim/ecl_loader_tb.sv]
// Bench: config cycles and host pins driven on falling edges.
// EEPROM lines are open drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        dis = 1'b0;
	logic        aux = 1'b1;
	logic        bad = 1'b0;
	logic        hen = 1'b0;
	logic        hclk = 1'b1;
	logic        hdat = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [3:0]  be = 4'hF;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        rvalid, sda_oe, scl_oe, hout, busy, ok, pull;
	int          error_cnt = 0;
	int          total_checks = 0;
	wire         sda = !sda_oe && !pull;
	wire         scl = !scl_oe;
	ecl_loader ecl_loader_i (.I_CLK(clk), .I_RSTN(rstn), .I_CFG_WR(wr), .I_CFG_RD(rd),
		.I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata),
		.O_CFG_RVALID(rvalid), .I_EEPROM_LOAD_DISABLE_PIN(dis), .I_AUX_POWER_SENSE(aux),
		.I_EEPROM_DATA_LINE(sda), .O_EEPROM_DATA_LINE_O(), .O_EEPROM_DATA_LINE_OE(sda_oe),
		.O_EEPROM_CLOCK_LINE_O(), .O_EEPROM_CLOCK_LINE_OE(scl_oe), .I_HOST_EE_EN(hen),
		.I_HOST_EE_CLK(hclk), .I_HOST_EE_DAT(hdat), .O_HOST_EE_DAT(hout),
		.O_LOAD_BUSY(busy), .O_LOAD_OK(ok));
	ecl_ee_model ecl_ee_model_i (.i_scl(scl), .i_sda(sda), .i_bad(bad), .o_pull(pull));
	initial forever #5 clk = ~clk;
	always #80 if (hen) hclk = ~hclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_cfg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		wr = 1'b1;
		addr = a;
		be = b;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_cfg(input logic [7:0] a, input logic [31:0] e);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk(rvalid ? rdata : ~e, e);
		@(negedge clk);
	endtask
	task automatic boot(input logic d, input logic b);
		rstn = 1'b0;
		dis = d;
		bad = b;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 110000 && busy !== 1'b0; i++)
			@(negedge clk);
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		boot(1'b0, 1'b0);
		chk({30'h0, ok, busy}, 32'h2);
		chk(ecl_ee_model_i.ptr, 32'd8);
		chk({31'h0, ecl_ee_model_i.nak}, 32'h1);
		rd_cfg(8'h2C, 32'h5678_1234);
		rd_cfg(8'hF8, 32'hA83C_0000);
		rd_cfg(8'h40, 32'h7F62_0001);
		wr_cfg(8'hFC, 4'h3, 32'hAAAA_BEEF);
		rd_cfg(8'h2C, 32'h5678_BEEF);
		wr_cfg(8'hFC, 4'hF, 32'hCAFE_F00D);
		rd_cfg(8'h2C, 32'hCAFE_F00D);
		wr_cfg(8'h2C, 4'hF, 32'hFFFF_FFFF);
		rd_cfg(8'h2C, 32'hCAFE_F00D);
		rd_cfg(8'hFC, 32'h0);
		wr_cfg(8'hF8, 4'hF, 32'hFFFF_FFFF);
		rd_cfg(8'hF8, 32'hF8FF_FFFF);
		aux = 1'b0;
		repeat (4) @(negedge clk);
		rd_cfg(8'h40, 32'h7E22_0001);
		aux = 1'b1;
		repeat (4) @(negedge clk);
		rd_cfg(8'h40, 32'h7FE2_0001);
		wr_cfg(8'hF8, 4'hF, 32'h0000_0000);
		rd_cfg(8'h40, 32'h0622_0001);
		hen = 1'b1;
		@(negedge hclk);
		hdat = 1'b0;
		repeat (6) @(negedge clk);
		chk({29'h0, scl_oe, sda_oe, hout}, 32'h6);
		@(negedge hclk);
		hdat = 1'b1;
		repeat (6) @(negedge clk);
		chk({29'h0, scl_oe, sda_oe, hout}, 32'h5);
		hen = 1'b0;
		boot(1'b1, 1'b0);
		chk({30'h0, ok, busy}, 32'h0);
		chk(ecl_ee_model_i.ptr, 32'd8);
		rd_cfg(8'h2C, 32'h0);
		rd_cfg(8'hF8, 32'h0);
		boot(1'b0, 1'b1);
		chk({30'h0, ok, busy}, 32'h0);
		rd_cfg(8'h2C, 32'h0);
		rd_cfg(8'hF8, 32'h0);
		report_and_stop();
	end
	initial begin
		#1000000;
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
